// *** mdds_pkg.sv ***
// Constants, carrier types and decode helpers for the multiplexed digit display scanner.
// Assumes one 25 MHz clock, a synchronous active-low reset and an AHB-Lite register bus.
// Functional notes
// - Sixteen BCD words kept in 64-bit recirculating register
// - Words read sequentially, written back, contents preserved
// - Host clock counts 64 loads, then display blocks loading
// - At display start, oscillator (or host clock when selected) shifts register and times scan
// - Load state inhibits counters, blanking forces decoders off
// - Decoder disable high drives all anode selects high
// - Terminal count flips control latch, releasing the counters
// - Anodes high four clocks, then exactly one falls
// - Fifth clock turns off; eighth fires next tube
// - Digit counter is four-bit binary, stepped by divide-by-four
// - Digit counter steps after every fourth shift pulse (oscillator, or host clock when selected)
// - Two one-of-eight decoders give sixteen active-low anodes
// - Four-bit register feeds shared BCD-to-decimal cathode lines
// - Tubes blanked for three of the four shifts while next word loads
// - Scan rate 3.2 kHz, under 10 kHz; host clock usable
package mdds_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int SCAN_HZ = 3200;
  localparam int SCAN_MAX_HZ = 10000;
  // Longest period allowed at the nominal rate rounds down; shortest period at the ceiling rounds up
  localparam int SCAN_DIV = CLK_HZ / SCAN_HZ;
  localparam int SCAN_DIV_MIN = (CLK_HZ + SCAN_MAX_HZ - 1) / SCAN_MAX_HZ;
  localparam int NUM_TUBES = 16;
  localparam int WORD_W = 4;
  localparam int SREG_W = 64;
  localparam logic [6:0] LOAD_LAST = 7'h3F;
  localparam logic [6:0] LOAD_DONE = 7'h40;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam int FIFO_W = 1;
  localparam int FIFO_D = 16;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DISP_LO = 8'h08;
  localparam logic [7:0] OFS_DISP_HI = 8'h0C;
  // CTRL fields
  localparam int CTRL_HOSTCLK_BIT = 0;
  localparam int CTRL_RELOAD_BIT = 1;
  localparam logic CTRL_HOSTCLK_RST = 1'b0;
  // STATUS fields
  localparam int ST_DISPLAY_BIT = 0;
  localparam int ST_BLANK_BIT = 1;
  localparam int ST_DIV4_LSB = 2;
  localparam int ST_DIGIT_LSB = 4;
  localparam int ST_LOADCNT_LSB = 8;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [15:0] ANODE_OFF = 16'hFFFF;
  localparam logic [9:0] CATHODE_OFF = 10'h3FF;

  typedef struct packed {
    logic clk_pin;
    logic data;
    logic write_info_n;
  } mdds_host_pins_t;

  typedef struct packed {
    logic [15:0] anode_n;
    logic [9:0] cathode_n;
  } mdds_disp_t;

  // One-of-eight decoder with active-high disable: all outputs high when disabled
  function automatic logic [7:0] mdds_dec8(input logic dis, input logic [2:0] sel);
    logic [7:0] r;
    r = 8'hFF;
    if (!dis) begin
      r[sel] = 1'b0;
    end
    return r;
  endfunction

  // Sixteen anode selects from two decoders; bit 3 steers which decoder is enabled
  function automatic logic [15:0] mdds_anode(input logic blank, input logic [3:0] d);
    return {mdds_dec8(blank | ~d[3], d[2:0]), mdds_dec8(blank | d[3], d[2:0])};
  endfunction

  // BCD to decimal, active low; codes above nine light nothing
  function automatic logic [9:0] mdds_bcd(input logic [3:0] w);
    logic [9:0] r;
    r = CATHODE_OFF;
    if (w <= 4'h9) begin
      r[w] = 1'b0;
    end
    return r;
  endfunction
endpackage

// *** mdds_scan.sv ***
// Serial load FIFO and the multiplexed digit display scanner with its AHB-Lite register slave.
// Assumes the host clock, data and write-information pins are asynchronous to clk.

module mdds_fifo #(
  parameter int W = 1,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } mdds_fifo_st_t;
  mdds_fifo_st_t s_ff, nxt_s;
  logic push, pop;

  assign in_ready = s_ff.cnt != (AW+1)'(D);
  assign out_valid = s_ff.cnt != '0;
  assign out_data = s_ff.mem[s_ff.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wr] = in_data;
      nxt_s.wr = AW'(s_ff.wr + 1'b1);
    end
    if (pop) begin
      nxt_s.rd = AW'(s_ff.rd + 1'b1);
    end
    nxt_s.cnt = (AW+1)'(s_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Occupancy never passes the depth and moves by exactly one per lone push or pop
  AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
    s_ff.cnt <= (AW+1)'(D))
    else $error("fifo count above depth");

  AST_FIFO_PUSH: assert property (@(posedge clk) disable iff (!rst_n)
    push && !pop
    |=> s_ff.cnt == (AW+1)'($past(s_ff.cnt) + 1'b1))
    else $error("fifo count did not rise on push");

  AST_FIFO_POP: assert property (@(posedge clk) disable iff (!rst_n)
    pop && !push
    |=> s_ff.cnt == (AW+1)'($past(s_ff.cnt) - 1'b1))
    else $error("fifo count did not fall on pop");

endmodule // mdds_fifo

module mdds_scan import mdds_pkg::*; #(
  parameter int SCAN_DIV_P = SCAN_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire mdds_host_pins_t host,
  output mdds_disp_t disp,
  output logic load_ready,
  output logic display_on,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  typedef struct packed {
    logic [1:0] hclk_sync;
    logic hclk_dly;
    logic [1:0] wr_sync;
    logic wr_dly;
    logic [1:0] dat_sync;
    logic [15:0] div_cnt;
    logic [SREG_W-1:0] sreg;
    logic [6:0] load_cnt;
    logic display;
    logic blank_n;
    logic [1:0] div4;
    logic [3:0] digit;
    logic [WORD_W-1:0] cath_sr;
    mdds_disp_t disp;
    logic hostclk_mode;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic load_ready;
  } mdds_st_t;

  localparam logic [15:0] DIV_LAST = 16'(SCAN_DIV_P - 1);

  mdds_st_t s_ff, nxt_s;
  logic hclk_rise, restart, reload_wr, osc_tick, tick, fire_word;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [FIFO_W-1:0] fifo_out_data;
  logic [WORD_W-1:0] new_word;

  function automatic logic [31:0] rd_mux(input mdds_st_t st, input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    unique case (a)
      OFS_CTRL: r[CTRL_HOSTCLK_BIT] = st.hostclk_mode;
      OFS_STATUS: begin
        r[ST_DISPLAY_BIT] = st.display;
        r[ST_BLANK_BIT] = st.blank_n;
        r[ST_DIV4_LSB +: 2] = st.div4;
        r[ST_DIGIT_LSB +: 4] = st.digit;
        r[ST_LOADCNT_LSB +: 7] = st.load_cnt;
      end
      OFS_DISP_LO: r = st.sreg[31:0];
      OFS_DISP_HI: r = st.sreg[63:32];
      default: r = '0;
    endcase
    return r;
  endfunction

  // Bits queue here until a load phase drains them; draining stalls while displaying
  mdds_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(hclk_rise & ~s_ff.wr_sync[1]),
    .in_ready(fifo_in_ready),
    .in_data(s_ff.dat_sync[1]),
    .out_valid(fifo_out_valid),
    .out_ready(~s_ff.display),
    .out_data(fifo_out_data)
  );

  assign hclk_rise = s_ff.hclk_sync[1] & ~s_ff.hclk_dly;
  assign fifo_pop = fifo_out_valid & ~s_ff.display;
  assign reload_wr = s_ff.ap_valid & s_ff.ap_write & (s_ff.ap_addr == OFS_CTRL) & hwdata[CTRL_RELOAD_BIT];
  assign restart = (s_ff.wr_dly & ~s_ff.wr_sync[1]) | reload_wr;
  assign osc_tick = s_ff.display & (s_ff.div_cnt == DIV_LAST);
  // Host clock may replace the local oscillator when it already lies in the scan range
  assign tick = s_ff.display & (s_ff.hostclk_mode ? hclk_rise : osc_tick);
  assign fire_word = tick & (s_ff.div4 == DIV4_LAST);
  assign new_word = {s_ff.sreg[0], s_ff.cath_sr[WORD_W-1:1]};

  always_comb begin
    nxt_s = s_ff;
    nxt_s.hclk_sync = {s_ff.hclk_sync[0], host.clk_pin};
    nxt_s.hclk_dly = s_ff.hclk_sync[1];
    nxt_s.wr_sync = {s_ff.wr_sync[0], host.write_info_n};
    nxt_s.wr_dly = s_ff.wr_sync[1];
    nxt_s.dat_sync = {s_ff.dat_sync[0], host.data};
    nxt_s.load_ready = fifo_in_ready;
    // Oscillator divider runs only in the scan phase so its first tick is a full period after release
    nxt_s.div_cnt = (s_ff.display && !osc_tick) ? 16'(s_ff.div_cnt + 1'b1) : '0;
    if (fifo_pop) begin
      nxt_s.sreg = {fifo_out_data, s_ff.sreg[SREG_W-1:1]};
      nxt_s.load_cnt = 7'(s_ff.load_cnt + 1'b1);
      if (s_ff.load_cnt == LOAD_LAST) begin
        nxt_s.display = 1'b1;
      end
    end
    if (tick) begin
      nxt_s.sreg = {s_ff.sreg[0], s_ff.sreg[SREG_W-1:1]};
      nxt_s.cath_sr = new_word;
      nxt_s.div4 = 2'(s_ff.div4 + 1'b1);
      if (fire_word) begin
        nxt_s.blank_n = 1'b1;
        nxt_s.disp.anode_n = mdds_anode(1'b0, s_ff.digit);
        nxt_s.disp.cathode_n = mdds_bcd(new_word);
        nxt_s.digit = 4'(s_ff.digit + 1'b1);
      end else if (s_ff.div4 == 2'h0) begin
        nxt_s.blank_n = 1'b0;
        nxt_s.disp.anode_n = mdds_anode(1'b1, s_ff.digit);
      end
    end
    if (restart) begin
      nxt_s.display = 1'b0;
      nxt_s.load_cnt = '0;
      nxt_s.blank_n = 1'b0;
      nxt_s.div4 = '0;
      nxt_s.digit = '0;
      nxt_s.div_cnt = '0;
      nxt_s.disp.anode_n = mdds_anode(1'b1, 4'h0);
      nxt_s.disp.cathode_n = CATHODE_OFF;
    end
    if (s_ff.ap_valid && s_ff.ap_write && s_ff.ap_addr == OFS_CTRL) begin
      nxt_s.hostclk_mode = hwdata[CTRL_HOSTCLK_BIT];
    end
    // Read data is sampled at the address phase so it stands from a flop during the data phase
    nxt_s.ap_valid = hsel & htrans[1] & hready;
    nxt_s.ap_write = hwrite & (hsize == HSIZE_WORD);
    nxt_s.ap_addr = {haddr[7:2], 2'b00};
    if (hsel && htrans[1] && hready && !hwrite) begin
      nxt_s.hrdata = rd_mux(s_ff, {haddr[7:2], 2'b00});
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.hclk_sync <= 2'h0;
      s_ff.wr_sync <= 2'h3;
      s_ff.wr_dly <= 1'b1;
      s_ff.hostclk_mode <= CTRL_HOSTCLK_RST;
      s_ff.disp.anode_n <= ANODE_OFF;
      s_ff.disp.cathode_n <= CATHODE_OFF;
      s_ff.load_ready <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign disp = s_ff.disp;
  assign load_ready = s_ff.load_ready;
  assign display_on = s_ff.display;
  assign hrdata = s_ff.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_RECIRC: assert property (tick && !restart |=> s_ff.sreg == {$past(s_ff.sreg[0]), $past(s_ff.sreg[63:1])})
    else $error("register did not recirculate on scan shift");
  AST_LOAD_END: assert property (fifo_pop && s_ff.load_cnt == LOAD_LAST && !restart |=> s_ff.display && s_ff.load_cnt == LOAD_DONE)
    else $error("display not entered after 64 loads");
  AST_NO_LOAD: assert property (s_ff.display |-> !fifo_pop ##1 (s_ff.load_cnt == $past(s_ff.load_cnt) || !s_ff.display))
    else $error("loading continued during display");
  AST_INHIBIT: assert property (!s_ff.display |-> s_ff.div4 == 2'h0 && s_ff.digit == 4'h0 && !s_ff.blank_n)
    else $error("counters not inhibited in load phase");
  AST_DISABLE: assert property (!s_ff.blank_n |-> s_ff.disp.anode_n == ANODE_OFF)
    else $error("anode active while blanked");
  AST_ONE_HOT: assert property (s_ff.blank_n |-> $countones(~s_ff.disp.anode_n) == 1)
    else $error("not exactly one anode selected");
  AST_FIRE: assert property (fire_word && !restart |=> s_ff.blank_n && s_ff.digit == 4'($past(s_ff.digit) + 1'b1) && !s_ff.disp.anode_n[$past(s_ff.digit)])
    else $error("tube did not fire after fourth shift");
  AST_OFF_FIFTH: assert property (tick && s_ff.div4 == 2'h0 |=> !s_ff.blank_n ##1 !s_ff.blank_n)
    else $error("anodes not off at fifth shift");
  AST_CATHODE: assert property (fire_word && !restart |=> s_ff.disp.cathode_n == mdds_bcd($past(new_word)))
    else $error("cathode decode mismatch");
  AST_RESTART: assert property (restart |=> !s_ff.display && s_ff.load_cnt == 7'h00 && s_ff.disp.anode_n == ANODE_OFF)
    else $error("restart did not return to load phase");
  AST_OSC_RANGE: assert property (s_ff.div_cnt <= DIV_LAST && !(osc_tick && !s_ff.hostclk_mode && !s_ff.display))
    else $error("scan divider out of range");

  // Hold, step and idle checks: each piece of state may move only on the event that owns it
  AST_SREG_HOLD: assert property (
    !fifo_pop && !tick
    |=> s_ff.sreg == $past(s_ff.sreg))
    else $error("display register changed without a load or shift");

  AST_LOAD_SHIFT: assert property (
    fifo_pop
    |=> s_ff.sreg == {$past(fifo_out_data), $past(s_ff.sreg[63:1])})
    else $error("loaded bit did not enter the top of the register");

  AST_LOAD_COUNT: assert property (
    fifo_pop && !restart
    |=> s_ff.load_cnt == 7'($past(s_ff.load_cnt) + 1'b1))
    else $error("load counter did not step on a loaded bit");

  AST_LOAD_HOLD: assert property (
    !fifo_pop && !restart
    |=> s_ff.load_cnt == $past(s_ff.load_cnt))
    else $error("load counter moved without a loaded bit");

  AST_DISPLAY_KEEP: assert property (
    s_ff.display && !restart
    |=> s_ff.display)
    else $error("scan phase left without a restart");

  AST_DISPLAY_EARLY: assert property (
    !s_ff.display && !(fifo_pop && s_ff.load_cnt == LOAD_LAST)
    |=> !s_ff.display)
    else $error("scan phase entered before terminal count");

  AST_OSC_IDLE: assert property (
    !s_ff.display
    |-> s_ff.div_cnt == 16'h0000)
    else $error("scan divider running in load phase");

  AST_OSC_STEP: assert property (
    s_ff.display && !osc_tick && !restart
    |=> s_ff.div_cnt == 16'($past(s_ff.div_cnt) + 1'b1))
    else $error("scan divider did not advance");

  AST_DIV4_STEP: assert property (
    tick && !restart
    |=> s_ff.div4 == 2'($past(s_ff.div4) + 1'b1))
    else $error("divide-by-four did not step on a shift");

  AST_DIV4_HOLD: assert property (
    !tick && !restart
    |=> s_ff.div4 == $past(s_ff.div4))
    else $error("divide-by-four moved without a shift");

  AST_DIGIT_HOLD: assert property (
    !fire_word && !restart
    |=> s_ff.digit == $past(s_ff.digit))
    else $error("digit counter moved between fourth shifts");

  AST_BLANK_HOLD: assert property (
    !tick && !restart
    |=> s_ff.blank_n == $past(s_ff.blank_n))
    else $error("blanking changed without a shift");

  AST_BLANK_SPAN: assert property (
    tick && s_ff.div4 != DIV4_LAST && !restart
    |=> !s_ff.blank_n)
    else $error("tube lit while the next word shifts in");

  AST_ANODE_HOLD: assert property (
    !tick && !restart
    |=> s_ff.disp.anode_n == $past(s_ff.disp.anode_n))
    else $error("anode select changed without a shift");

  AST_ANODE_LOAD: assert property (
    !s_ff.display
    |-> s_ff.disp.anode_n == ANODE_OFF)
    else $error("anode active in load phase");

  AST_FIRED_TUBE: assert property (
    s_ff.blank_n
    |-> !s_ff.disp.anode_n[4'(s_ff.digit - 1'b1)])
    else $error("lit anode does not match the digit just fired");

  AST_CATH_SHIFT: assert property (
    tick
    |=> s_ff.cath_sr == $past(new_word))
    else $error("cathode register did not take the shifted bit");

  AST_CATH_HOLD: assert property (
    !fire_word && !restart
    |=> s_ff.disp.cathode_n == $past(s_ff.disp.cathode_n))
    else $error("cathode lines changed between fires");

  AST_CATH_IDLE: assert property (
    !s_ff.display
    |-> s_ff.disp.cathode_n == CATHODE_OFF)
    else $error("cathode active in load phase");

  AST_READY_FLOP: assert property (
    1'b1
    |=> s_ff.load_ready == $past(fifo_in_ready))
    else $error("load ready does not follow fifo space");

  // Bus side: read data and the mode bit stand until their own access
  AST_RDATA_HOLD: assert property (
    !(hsel && htrans[1] && hready && !hwrite)
    |=> s_ff.hrdata == $past(s_ff.hrdata))
    else $error("read data changed without a read");

  AST_MODE_HOLD: assert property (
    !(s_ff.ap_valid && s_ff.ap_write && s_ff.ap_addr == OFS_CTRL)
    |=> s_ff.hostclk_mode == $past(s_ff.hostclk_mode))
    else $error("clock mode changed without a control write");

  AST_RESTART_CLR: assert property (
    restart
    |=> s_ff.digit == 4'h0 && s_ff.div4 == 2'h0 && !s_ff.blank_n && s_ff.disp.cathode_n == CATHODE_OFF)
    else $error("restart left scan counters running");
endmodule // mdds_scan

// *** mdds_host_model.sv ***
// Host calculator model: drives the serial load pins of the display scanner.
// Assumes a free-running clk; a one-cycle go starts one frame of nbits bits.
module mdds_host_model import mdds_pkg::*; (
  input wire logic clk,
  input wire logic go,
  input wire logic slow,
  input wire logic [6:0] nbits,
  input wire logic [63:0] words,
  output mdds_host_pins_t host,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int h;
  initial begin
    host = 3'h1;
    busy = 1'b0;
  end
  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      h = slow ? 7 : 3;
      host.write_info_n <= 1'b0;
      // Give the restart time to land before the first bit
      repeat (h) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
        host.data <= words[i % 64];
        repeat (h) @(posedge clk);
        host.clk_pin <= 1'b1;
        repeat (h) @(posedge clk);
        host.clk_pin <= 1'b0;
      end
      repeat (h) @(posedge clk);
      host.write_info_n <= 1'b1;
      // Released data line must not keep looking valid
      host.data <= ~host.data;
      busy <= 1'b0;
    end
  end
endmodule // mdds_host_model

// *** mdds_scan_tb_top.sv ***
// Testbench for the multiplexed digit display scanner: AHB-Lite accesses, serial loads, scan timing.
// Assumes mdds_host_model as the host and a scan divider shortened to eight cycles.
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
  end \
end
`define WAITC(c) begin \
  n = 0; \
  while (!(c) && n < 3000) begin \
    @(posedge clk); \
    n++; \
  end \
  if (n >= 3000) begin \
    num_errors++; \
    results(); \
  end \
end
module mdds_scan_tb_top import mdds_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SD = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [6:0] nbits = 7'h40;
  logic [63:0] words = 64'h0;
  logic [63:0] pa;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic busy, load_ready, display_on, hreadyout, hresp;
  logic [15:0] ea;
  logic [9:0] ec;
  logic [3:0] ew;
  mdds_host_pins_t host;
  mdds_disp_t disp;
  int num_errors = 0;
  int n_compared = 0;
  int n, w;

  mdds_host_model host_u (.clk(clk), .go(go), .slow(slow), .nbits(nbits), .words(words), .host(host),
    .busy(busy));
  mdds_scan #(.SCAN_DIV_P(SD)) dut_u (.clk(clk), .rst_n(rst_n), .host(host), .disp(disp),
    .load_ready(load_ready), .display_on(display_on), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk);
    `WAITC(hreadyout === 1'b1)
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    `WAITC(hreadyout === 1'b1)
    rd = hrdata;
  endtask

  task automatic load(input logic [63:0] p, input logic s, input logic [6:0] nb);
    words <= p;
    slow <= s;
    nbits <= nb;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  initial begin
    // Codes above nine included: they must light no cathode
    for (int k = 0; k < 16; k++) begin
      pa[4*k +: 4] = (k < 10) ? 4'(9 - k) : 4'(k);
    end
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("anode", ANODE_OFF, disp.anode_n)
    `CHK("cathode", CATHODE_OFF, disp.cathode_n)
    `CHK("display", 1'b0, display_on)
    `CHK("hresp", 1'b0, hresp)
    ahb(1'b1, 32'(OFS_CTRL), 32'h1);
    ahb(1'b0, 32'(OFS_CTRL), 32'h0);
    `CHK("hostclk_mode", 32'h1, rd)
    ahb(1'b1, 32'(OFS_CTRL), 32'h0);
    ahb(1'b0, 32'h10, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    load(pa, 1'b0, 7'h40);
    `WAITC(display_on === 1'b1)
    ahb(1'b0, 32'(OFS_DISP_LO), 32'h0);
    `CHK("disp_lo", pa[31:0], rd)
    ahb(1'b0, 32'(OFS_DISP_HI), 32'h0);
    `CHK("disp_hi", pa[63:32], rd)
    // Seventeen fires: the last one proves the words came round intact
    for (int t = 0; t < 17; t++) begin
      `WAITC(disp.anode_n !== ANODE_OFF)
      if (t > 0) `CHK("gap", 3 * SD, n)
      ew = pa[4 * (t % 16) +: 4];
      ea = ~(16'h0001 << (t % 16));
      ec = (ew <= 4'h9) ? ~(10'h001 << ew) : CATHODE_OFF;
      `CHK("anode", ea, disp.anode_n)
      `CHK("cathode", ec, disp.cathode_n)
      w = 0;
      while (disp.anode_n === ea && w < 100) begin
        @(posedge clk);
        w++;
      end
      `CHK("fire_width", SD, w)
    end
    load(64'h0123_4567_89AB_CDEF, 1'b1, 7'h51);
    `WAITC(display_on === 1'b0)
    `CHK("anode_restart", ANODE_OFF, disp.anode_n)
    `WAITC(busy === 1'b0)
    `CHK("display", 1'b1, display_on)
    `CHK("fifo_full", 1'b0, load_ready)
    ahb(1'b0, 32'(OFS_STATUS), 32'h0);
    `CHK("load_cnt", 7'h40, rd[14:8])
    ahb(1'b1, 32'(OFS_CTRL), 32'h2);
    `WAITC(display_on === 1'b0)
    // Sixteen held bits drain into the fresh load; poll rather than assume the pop rate
    for (int k = 0; k < 20 && rd[14:8] !== 7'h10; k++) begin
      ahb(1'b0, 32'(OFS_STATUS), 32'h0);
    end
    `CHK("load_cnt_fifo", 7'h10, rd[14:8])
    `CHK("status_display", 1'b0, rd[ST_DISPLAY_BIT])
    `CHK("fifo_drained", 1'b1, load_ready)
    `CHK("anode_load", ANODE_OFF, disp.anode_n)
    results();
  end
endmodule // mdds_scan_tb_top
